// ### common/ccm_pkg.sv
package ccm_pkg;

  // ==========================================================================
  // Clock and count limits
  // ==========================================================================
  localparam int unsigned CLK_MHZ      = 200;
  localparam logic [31:0] CNT_UPPER    = 32'h7FFFFFFF;
  localparam logic [31:0] CNT_LOWER    = 32'h80000000;
  localparam logic [31:0] CNT_RESET    = 32'h00000000;

  // ==========================================================================
  // Maximum-frequency selection and minimum pulse widths
  // ==========================================================================
  localparam logic [2:0] FREQ_1K   = 3'h0;
  localparam logic [2:0] FREQ_2K   = 3'h1;
  localparam logic [2:0] FREQ_5K   = 3'h2;
  localparam logic [2:0] FREQ_10K  = 3'h3;
  localparam logic [2:0] FREQ_30K  = 3'h4;
  localparam logic [2:0] FREQ_60K  = 3'h5;
  localparam logic [2:0] FREQ_RESET = FREQ_60K;

  // Shortest accepted pulse in nanoseconds, as printed.
  localparam int unsigned WIDTH_1K_NS  = 400000;
  localparam int unsigned WIDTH_2K_NS  = 200000;
  localparam int unsigned WIDTH_5K_NS  = 80000;
  localparam int unsigned WIDTH_10K_NS = 40000;
  localparam int unsigned WIDTH_30K_NS = 13000;
  localparam int unsigned WIDTH_60K_NS = 6700;

  // Cycle counts; a least time rounds up.
  localparam int unsigned CYC_1K  = (WIDTH_1K_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_2K  = (WIDTH_2K_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_5K  = (WIDTH_5K_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_10K = (WIDTH_10K_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_30K = (WIDTH_30K_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_60K = (WIDTH_60K_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned FILT_W = 17;

  // ==========================================================================
  // Modes
  // ==========================================================================
  localparam logic MODE_CONTINUOUS = 1'b0;
  localparam logic MODE_ONCE       = 1'b1;
  localparam logic GATE_ABORT      = 1'b0;
  localparam logic GATE_INTERRUPT  = 1'b1;

  typedef enum logic [2:0] {
    CCM_IDLE   = 3'b001,
    CCM_RUN    = 3'b010,
    CCM_CLOSED = 3'b100
  } ccm_state_t;

  function automatic logic [FILT_W-1:0] ccm_width(input logic [2:0] sel);
    case (sel)
      FREQ_1K:  ccm_width = FILT_W'(CYC_1K);
      FREQ_2K:  ccm_width = FILT_W'(CYC_2K);
      FREQ_5K:  ccm_width = FILT_W'(CYC_5K);
      FREQ_10K: ccm_width = FILT_W'(CYC_10K);
      FREQ_30K: ccm_width = FILT_W'(CYC_30K);
      default:  ccm_width = FILT_W'(CYC_60K);
    endcase
  endfunction : ccm_width

endpackage : ccm_pkg

// ### rtl/ccm_counter.sv
`timescale 1ns/1ps
// Function
// - Continuous start loads load value
// - Up past upper limit wraps lower
// - Down past lower limit wraps upper
// - Limits fixed to full signed range
// - Sticky overflow/underflow flags until clear command
// - Interrupt request only when source enabled
// - Single-shot counts both ways from load
// - Single-shot limit hit loads opposite, closes gate
// - Restart needs rising gate edge
// - Single-shot interrupt gate mode resumes held value
// - Abort gate mode reloads load value
// - Frequency select sets count input width
// - Separate frequency select for latch
// - Interrupt enables separate, default disabled
module ccm_counter
  import ccm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        trackA,
  input  wire logic        trackB,
  input  wire logic        gateIn,
  input  wire logic        latchIn,
  input  wire logic        modeOnce,
  input  wire logic        gateInterrupt,
  input  wire logic [2:0]  countFreqSel,
  input  wire logic [2:0]  latchFreqSel,
  input  wire logic [31:0] loadValue,
  input  wire logic        overflowIrqEn,
  input  wire logic        underflowIrqEn,
  input  wire logic        status_clear_cmd,
  output logic [31:0]      countValue,
  output logic [31:0]      latchValue,
  output logic             overflow_flag,
  output logic             underflow_flag,
  output logic             overflowIrq,
  output logic             underflowIrq,
  output logic             gateOpen
);

  // ==========================================================================
  // Input qualification
  // ==========================================================================
  logic pulseLvl;
  logic dirLvl;
  logic gateLvl;
  logic latchLvl;

  ccm_pulse_filter uFiltA (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .freqSel  (countFreqSel),
    .rawIn    (trackA),
    .filtOut  (pulseLvl)
  );

  ccm_pulse_filter uFiltB (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .freqSel  (countFreqSel),
    .rawIn    (trackB),
    .filtOut  (dirLvl)
  );

  ccm_pulse_filter uFiltGate (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .freqSel  (countFreqSel),
    .rawIn    (gateIn),
    .filtOut  (gateLvl)
  );

  ccm_pulse_filter uFiltLatch (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .freqSel  (latchFreqSel),
    .rawIn    (latchIn),
    .filtOut  (latchLvl)
  );

  // ==========================================================================
  // Edge detection on qualified levels
  // ==========================================================================
  logic pulsePrev;
  logic gatePrev;
  logic latchPrev;
  logic pulseRise;
  logic gateRise;
  logic gateFall;
  logic latchRise;
  logic next_pulsePrev;
  logic next_gatePrev;
  logic next_latchPrev;

  // Each previous level trails its qualified input by one cycle.
  always_comb begin
    next_pulsePrev = pulseLvl;
    next_gatePrev  = gateLvl;
    next_latchPrev = latchLvl;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pulsePrev <= 1'b0;
      gatePrev  <= 1'b0;
      latchPrev <= 1'b0;
    end else begin
      pulsePrev <= next_pulsePrev;
      gatePrev  <= next_gatePrev;
      latchPrev <= next_latchPrev;
    end
  end

  assign pulseRise = pulseLvl & ~pulsePrev;
  assign gateRise  = gateLvl & ~gatePrev;
  assign gateFall  = ~gateLvl & gatePrev;
  assign latchRise = latchLvl & ~latchPrev;

  // ==========================================================================
  // Gate and count state
  // ==========================================================================
  ccm_state_t  state;
  ccm_state_t  next_state;
  logic [31:0] next_countValue;
  logic [31:0] next_latchValue;
  logic        next_overflow_flag;
  logic        next_underflow_flag;
  logic        next_overflowIrq;
  logic        next_underflowIrq;
  logic        hitOver;
  logic        hitUnder;
  logic        countUp;

  always_comb begin
    next_state          = state;
    next_countValue     = countValue;
    next_latchValue     = latchValue;
    hitOver             = 1'b0;
    hitUnder            = 1'b0;
    countUp             = ~dirLvl;
    case (state)
      CCM_IDLE: begin
        if (gateRise) begin
          next_state      = CCM_RUN;
          next_countValue = loadValue;
        end
      end
      CCM_RUN: begin
        if (gateFall) begin
          next_state = CCM_IDLE;
        end else if (pulseRise) begin
          if (countUp && countValue == CNT_UPPER) begin
            hitOver         = 1'b1;
            next_countValue = CNT_LOWER;
          end else if (!countUp && countValue == CNT_LOWER) begin
            hitUnder        = 1'b1;
            next_countValue = CNT_UPPER;
          end else if (countUp) begin
            next_countValue = countValue + 32'h00000001;
          end else begin
            next_countValue = countValue - 32'h00000001;
          end
          if ((hitOver || hitUnder) && modeOnce == MODE_ONCE) begin
            next_state = CCM_CLOSED;
          end
        end
        if (latchRise) begin
          next_latchValue = countValue;
        end
      end
      CCM_CLOSED: begin
        if (gateRise) begin
          next_state = CCM_RUN;
          if (gateInterrupt == GATE_ABORT) begin
            next_countValue = loadValue;
          end else begin
            next_countValue = countValue;
          end
        end
      end
      default: begin
        next_state = CCM_IDLE;
      end
    endcase
    if (state == CCM_IDLE && gateRise && gateInterrupt == GATE_INTERRUPT
        && modeOnce == MODE_ONCE) begin
      next_countValue = countValue;
    end
    // The set wins over a clear in the same cycle.
    next_overflow_flag  = (overflow_flag & ~status_clear_cmd) | hitOver;
    next_underflow_flag = (underflow_flag & ~status_clear_cmd) | hitUnder;
    next_overflowIrq    = hitOver & overflowIrqEn;
    next_underflowIrq   = hitUnder & underflowIrqEn;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state          <= CCM_IDLE;
      countValue     <= CNT_RESET;
      latchValue     <= CNT_RESET;
      overflow_flag  <= 1'b0;
      underflow_flag <= 1'b0;
      overflowIrq    <= 1'b0;
      underflowIrq   <= 1'b0;
    end else begin
      state          <= next_state;
      countValue     <= next_countValue;
      latchValue     <= next_latchValue;
      overflow_flag  <= next_overflow_flag;
      underflow_flag <= next_underflow_flag;
      overflowIrq    <= next_overflowIrq;
      underflowIrq   <= next_underflowIrq;
    end
  end

  // Pulses are counted only while the machine sits in the running state.
  assign gateOpen = (state == CCM_RUN);

endmodule : ccm_counter

// ### rtl/ccm_pulse_filter.sv
`timescale 1ns/1ps
module ccm_pulse_filter
  import ccm_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [2:0]        freqSel,
  input  wire logic              rawIn,
  output logic                   filtOut
);

  logic [FILT_W-1:0] stableCnt;
  logic [FILT_W-1:0] next_stableCnt;
  logic              next_filtOut;

  // ==========================================================================
  // Accept a new level only after it has stood for the minimum width
  // ==========================================================================
  always_comb begin
    next_stableCnt = stableCnt;
    next_filtOut   = filtOut;
    if (rawIn == filtOut) begin
      next_stableCnt = '0;
    end else if (stableCnt + FILT_W'(1) >= ccm_width(freqSel)) begin
      next_stableCnt = '0;
      next_filtOut   = rawIn;
    end else begin
      next_stableCnt = stableCnt + FILT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stableCnt <= '0;
      filtOut   <= 1'b0;
    end else begin
      stableCnt <= next_stableCnt;
      filtOut   <= next_filtOut;
    end
  end

endmodule : ccm_pulse_filter

// ### sim/ccm_counter_assertions.sv
`timescale 1ns/1ps
module ccm_counter_checker
  import ccm_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        modeOnce,
  input wire logic        gateInterrupt,
  input wire logic [31:0] loadValue,
  input wire logic        overflowIrqEn,
  input wire logic        underflowIrqEn,
  input wire logic        status_clear_cmd,
  input wire logic [31:0] countValue,
  input wire logic        overflow_flag,
  input wire logic        underflow_flag,
  input wire logic        overflowIrq,
  input wire logic        underflowIrq,
  input wire logic        gateOpen
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ====================
  // Checks.
  a_ovf_irq_gate: assert property (overflowIrq |-> overflowIrqEn && overflow_flag)
    else $error("overflow request without enable");
  a_udf_irq_gate: assert property (underflowIrq |-> underflowIrqEn && underflow_flag)
    else $error("underflow request without enable");
  a_flag_sticky: assert property (!$past(sys_rst) && $past(overflow_flag)
    && !$past(status_clear_cmd) |-> overflow_flag) else $error("overflow flag lost");
  a_clear_flags: assert property ($past(status_clear_cmd) && $stable(countValue)
    |-> !overflow_flag && !underflow_flag) else $error("flags not cleared");
  a_once_closes: assert property (modeOnce && $past(gateOpen) && countValue == CNT_LOWER
    && $past(countValue) == CNT_UPPER |-> !gateOpen) else $error("gate still open");
  a_closed_holds: assert property (!gateOpen && !$past(gateOpen) && !$past(sys_rst)
    |-> $stable(countValue)) else $error("count moved while closed");
  a_open_loads: assert property ($rose(gateOpen) && !(modeOnce && gateInterrupt)
    |-> countValue == loadValue) else $error("load value not taken");
  a_step_one: assert property ($past(gateOpen) && gateOpen && !$stable(countValue)
    |-> countValue == $past(countValue) + 1 || countValue == $past(countValue) - 1)
    else $error("count step not one");
  c_ovf: cover property (overflowIrq);
  c_udf: cover property (underflowIrq);
  c_close: cover property (modeOnce && $fell(gateOpen));
endmodule : ccm_counter_checker

// ### sim/ccm_pulse_source.sv
`timescale 1ns/1ps
module ccm_pulse_source
  import ccm_pkg::*;
(
  input  wire logic core_clk,
  output logic      trackA,
  output logic      trackB
);
  localparam int W = CYC_60K + 8;
  initial begin
    trackA = 1'b0;
    trackB = 1'b0;
  end
  // ====================
  // Each level stands past the 60 kHz filter unless hi is made shorter.
  task automatic pulse(input logic down, input int hi);
    @(negedge core_clk);
    trackB = down;
    repeat (W) @(negedge core_clk);
    trackA = 1'b1;
    repeat (hi) @(negedge core_clk);
    trackA = 1'b0;
    repeat (W) @(negedge core_clk);
  endtask : pulse
endmodule : ccm_pulse_source

// ### sim/counter_continuous_once_modes_tb.sv
`timescale 1ns/1ps
module counter_continuous_once_modes_tb
  import ccm_pkg::*;
;
  localparam int W = CYC_60K + 8;
  logic core_clk, sys_rst, trackA, trackB, gateIn, latchIn, modeOnce, gateInterrupt;
  logic overflowIrqEn, underflowIrqEn, status_clear_cmd, overflow_flag, underflow_flag;
  logic overflowIrq, underflowIrq, gateOpen;
  logic [31:0] loadValue, countValue, latchValue;
  logic [2:0]  countFreqSel, latchFreqSel;
  int errors, total_checks, ovfIrqs, udfIrqs;
  ccm_counter uut (.core_clk, .sys_rst, .trackA, .trackB, .gateIn, .latchIn, .modeOnce,
    .gateInterrupt, .countFreqSel, .latchFreqSel, .loadValue,
    .overflowIrqEn, .underflowIrqEn, .status_clear_cmd, .countValue, .latchValue,
    .overflow_flag, .underflow_flag, .overflowIrq, .underflowIrq, .gateOpen);
  ccm_pulse_source src (.core_clk, .trackA, .trackB);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (overflowIrq === 1'b1) ovfIrqs++;
    if (underflowIrq === 1'b1) udfIrqs++;
  end
  // ====================
  // Helpers.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic gate(input logic v);
    @(negedge core_clk);
    gateIn = v;
    repeat (W) @(negedge core_clk);
  endtask : gate
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // ====================
  // Scenarios.
  task automatic test_cont;
    overflowIrqEn = 1'b1;
    loadValue = CNT_UPPER - 32'h1;
    gate(1'b1);
    check(countValue, CNT_UPPER - 32'h1);
    src.pulse(1'b0, W);
    check(countValue, CNT_UPPER);
    src.pulse(1'b0, CYC_60K / 2);
    check(countValue, CNT_UPPER);
    countFreqSel = FREQ_30K;
    src.pulse(1'b0, W + W / 2);
    check(countValue, CNT_UPPER);
    countFreqSel = FREQ_60K;
    src.pulse(1'b0, W);
    check(32'({countValue == CNT_LOWER, overflow_flag, ovfIrqs == 1}), 32'h7);
    src.pulse(1'b1, W);
    check(32'({countValue == CNT_UPPER, underflow_flag, udfIrqs == 0, overflow_flag}), 32'hF);
    latchFreqSel = FREQ_30K;
    latchIn = 1'b1;
    repeat (W + W / 2) @(negedge core_clk);
    latchIn = 1'b0;
    repeat (W) @(negedge core_clk);
    check(latchValue, CNT_RESET);
    latchFreqSel = FREQ_60K;
    latchIn = 1'b1;
    repeat (W) @(negedge core_clk);
    latchIn = 1'b0;
    repeat (W) @(negedge core_clk);
    check(latchValue, CNT_UPPER);
    status_clear_cmd = 1'b1;
    @(negedge core_clk);
    status_clear_cmd = 1'b0;
    @(negedge core_clk);
    check(32'({overflow_flag, underflow_flag}), 32'h0);
    gate(1'b0);
    $display("continuous test done");
  endtask : test_cont
  task automatic test_once_abort;
    modeOnce = 1'b1;
    underflowIrqEn = 1'b1;
    loadValue = CNT_UPPER;
    gate(1'b1);
    check(countValue, CNT_UPPER);
    src.pulse(1'b0, W);
    check(32'({countValue == CNT_LOWER, gateOpen, ovfIrqs == 2}), 32'h5);
    src.pulse(1'b0, W);
    check(countValue, CNT_LOWER);
    gate(1'b0);
    gate(1'b1);
    check(32'({countValue == CNT_UPPER, gateOpen}), 32'h3);
    src.pulse(1'b1, W);
    check(countValue, CNT_UPPER - 32'h1);
    gate(1'b0);
    $display("single-shot abort test done");
  endtask : test_once_abort
  task automatic test_once_interrupt;
    gateInterrupt = 1'b1;
    gate(1'b1);
    check(countValue, CNT_UPPER - 32'h1);
    src.pulse(1'b0, W);
    src.pulse(1'b0, W);
    check(32'({countValue == CNT_LOWER, gateOpen}), 32'h2);
    gate(1'b0);
    gate(1'b1);
    check(countValue, CNT_LOWER);
    src.pulse(1'b1, W);
    check(32'({countValue == CNT_UPPER, gateOpen, underflow_flag, udfIrqs == 1}), 32'hB);
    $display("single-shot interrupt test done");
  endtask : test_once_interrupt
  initial begin
    sys_rst = 1'b1;
    {gateIn, latchIn, modeOnce, gateInterrupt, status_clear_cmd} = 5'h00;
    {overflowIrqEn, underflowIrqEn} = 2'h0;
    loadValue = 32'h00000000;
    countFreqSel = FREQ_60K;
    latchFreqSel = FREQ_60K;
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    check(countValue, CNT_RESET);
    check(32'({overflow_flag, underflow_flag, gateOpen}), 32'h0);
    test_cont();
    test_once_abort();
    test_once_interrupt();
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    complete_run();
  end
endmodule : counter_continuous_once_modes_tb
bind ccm_counter ccm_counter_checker chk (.core_clk, .sys_rst, .modeOnce, .gateInterrupt,
  .loadValue, .overflowIrqEn, .underflowIrqEn, .status_clear_cmd, .countValue,
  .overflow_flag, .underflow_flag, .overflowIrq, .underflowIrq, .gateOpen);
